// ---- core/pcbbh_top.sv ----
// pmbus command buffering and busy handshake, device side
`timescale 1ns/1ps
`default_nettype none
`include "pcbbh_regs.svh"

// Functional notes
// - Every supported command owns one buffer entry holding its latest written data.
// - A write stores data, marks the command for fetch, then it is executed.
// - Bus buffering and processor execution run in parallel; no written data is lost.
// - Queued commands may execute late and out of arrival order.
// - Status bit 5 is zero while calculation is pending, one when ready.
// - Status bit 6 is zero while any internal operation executes.
// - Status bit 4 is zero while an output is in transition.
// - A command while busy is NACKed or reads return 0xFF, by configuration.
// - Busy also raises a BUSY fault with ALERT, unless it stretches SCL instead.
// - Stretching is enabled only by bit 1 of global configuration.
// - Stretch only when enabled and bus runs above 100kHz; else other responses.
// - With all three flags set the next command gets no busy NACK or fault.
// - Unsupported command codes or invalid data are always NACKed.
// - Stretching never allows bus speed beyond 400kHz; here any scl speed above 100kHz stretches, with no upper limit.
module pcbbh_top #(
	parameter logic [255:0] CMD_SUPPORTED = {256{1'b1}},
	parameter int           EXEC_CYCLES   = `PCBBH_EXEC_CYC_DEF
)(
	// clocks and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        scl_clk,
	// bus pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	// configuration
	input  wire logic [6:0]  dev_addr,
	input  wire logic [7:0]  global_config,
	input  wire logic        busy_nack_mode,
	// device state and faults
	input  wire logic        out_transition,
	input  wire logic        fault_clear,
	output logic             busy_fault,
	output logic             alert_n,
	// processor side
	output logic             exec_valid,
	output logic [7:0]       exec_cmd,
	output logic [15:0]      exec_data
);
	import pcbbh_pkg::*;

	typedef struct packed {
		logic          scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
		logic          ct_s1, ct_s2, ct_d, wt_s1, wt_s2, wt_d;
		logic          frame_run, started;
		logic [11:0]   per_cnt;
		logic          fast, stretch, hold_req, hold, fault;
		logic          wdirty;
		logic [7:0]    wcmd;
		logic [255:0]  pend;
		pcbbh_pstate_t pstate;
		logic [7:0]    pcmd;
		logic [15:0]   timer;
		logic          exec_valid;
		logic [7:0]    exec_cmd;
		logic [15:0]   exec_data;
		logic [7:0]    status;
	} pcbbh_sys_t;

	typedef struct packed {
		pcbbh_lstate_t state;
		logic [3:0]    cnt;
		logic [7:0]    shift;
		logic          ack;
		logic [7:0]    tx;
	} pcbbh_frm_t;

	typedef struct packed {
		logic [3:0] sy1, sy2;
		logic [7:0] cmd;
		logic       have_cmd;
		logic [1:0] idx;
		logic       wr_hi;
		logic [7:0] wdata;
		logic       wr_tgl, cmd_tgl;
	} pcbbh_lnk_t;

	localparam logic [11:0] SLOW_PER = 12'(`PCBBH_SLOW_PERIOD_CYC);
	// fetch cycle plus the execute countdown, fetch to exec_valid
	localparam int          EXEC_DLY = EXEC_CYCLES + 1;

	function automatic logic [8:0] first_pending(input logic [255:0] v);
		logic [8:0] r;
		r = 9'h100;
		for (int i = 255; i >= 0; i--)
			if (v[i])
				r = {1'b0, 8'(i)};
		return r;
	endfunction

	function automatic logic cmd_ok(input logic [7:0] c);
		return CMD_SUPPORTED[c];
	endfunction

	pcbbh_sys_t s, sn;
	pcbbh_frm_t f, fn;
	pcbbh_lnk_t k, kn;
	logic       sda_drv_ff;
	logic       cmd_evt, wr_evt, bus_evt, ready, frm_arst_n;
	logic [8:0] pick;
	logic       rdy_l, blk_l;
	logic [7:0] byte_l, stat_l, rd_l;

	pcbbh_mem_if #(.AW(`PCBBH_CMD_W), .DW(`PCBBH_DATA_W)) mb ();

	pcbbh_mem #(.AW(`PCBBH_CMD_W), .DW(`PCBBH_DATA_W)) u_mem (
		.clock (clock),
		.bus   (mb.mem)
	);

	assign cmd_evt    = s.ct_s2 ^ s.ct_d;
	assign wr_evt     = s.wt_s2 ^ s.wt_d;
	assign bus_evt    = s.scl_s2 && s.scl_d && (s.sda_d != s.sda_s2);
	assign ready      = &s.status[6:4];
	assign pick       = first_pending(s.pend);
	// link frame logic held in reset from start/stop until scl falls
	assign frm_arst_n = arst_n & s.frame_run;

	// buffer write on every accepted data byte, read at the pick
	assign mb.we    = wr_evt;
	assign mb.waddr = k.cmd;
	assign mb.wbe   = k.wr_hi ? 2'b10 : 2'b01;
	assign mb.wdata = {2{k.wdata}};
	assign mb.raddr = pick[7:0];

	// system domain
	always_comb
	begin
		sn = s;
		sn.scl_s1 = scl_i;
		sn.scl_s2 = s.scl_s1;
		sn.scl_d = s.scl_s2;
		sn.sda_s1 = sda_i;
		sn.sda_s2 = s.sda_s1;
		sn.sda_d = s.sda_s2;
		sn.ct_s1 = k.cmd_tgl;
		sn.ct_s2 = s.ct_s1;
		sn.ct_d = s.ct_s2;
		sn.wt_s1 = k.wr_tgl;
		sn.wt_s2 = s.wt_s1;
		sn.wt_d = s.wt_s2;
		sn.exec_valid = 1'b0;
		if (bus_evt)
		begin
			sn.frame_run = 1'b0;
			sn.started = s.sda_d;
		end
		else if (s.started && !s.scl_s2)
		begin
			sn.frame_run = 1'b1;
			sn.started = 1'b0;
		end
		// scl period measure; saturates at 4095 cycles, near 30kHz, which reads as slow
		if (s.scl_s2 && !s.scl_d)
		begin
			sn.fast = s.per_cnt < SLOW_PER;
			sn.per_cnt = 12'h000;
		end
		else if (s.per_cnt != 12'hFFF && !s.hold)
			sn.per_cnt = s.per_cnt + 12'h001;
		else if (!s.hold)
			sn.fast = 1'b0;
		sn.stretch = global_config[`PCBBH_CFG_STRETCH_BIT] && s.fast;
		// busy response on a command byte
		if (fault_clear)
			sn.fault = 1'b0;
		if (cmd_evt && !ready && k.cmd != `PCBBH_STATUS_CMD)
		begin
			if (s.stretch)
				sn.hold_req = 1'b1;
			else
				sn.fault = 1'b1;
		end
		if (s.hold_req && !s.scl_s2)
			sn.hold = 1'b1;
		if (ready)
		begin
			sn.hold_req = 1'b0;
			sn.hold = 1'b0;
		end
		// processor: lowest pending code first
		case (s.pstate)
			P_IDLE:
				if (!pick[8])
				begin
					sn.pend[pick[7:0]] = 1'b0;
					sn.pcmd = pick[7:0];
					sn.pstate = P_FETCH;
				end
			P_FETCH:
			begin
				sn.exec_cmd = s.pcmd;
				sn.exec_data = mb.rdata;
				sn.timer = 16'(EXEC_CYCLES);
				sn.pstate = P_EXEC;
			end
			P_EXEC:
			begin
				sn.timer = s.timer - 16'h0001;
				if (s.timer <= 16'h0001)
				begin
					sn.exec_valid = 1'b1;
					sn.pstate = P_IDLE;
				end
			end
			default: sn.pstate = P_IDLE;
		endcase
		// mark for fetch at end of transfer; set wins over fetch clear
		if (wr_evt)
		begin
			sn.wdirty = 1'b1;
			sn.wcmd = k.cmd;
		end
		else if (bus_evt && s.wdirty)
		begin
			sn.pend[s.wcmd] = 1'b1;
			sn.wdirty = 1'b0;
		end
		sn.status = 8'h00;
		sn.status[6] = !(s.pstate != P_IDLE || out_transition);
		sn.status[5] = !(s.pstate != P_IDLE || !pick[8] || s.wdirty || wr_evt);
		sn.status[4] = !out_transition;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			// pin synchronisers start at the idle bus level, so no false edge follows reset
			s <= '{status: `PCBBH_STATUS_IDLE, pstate: P_IDLE,
				scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
				default: '0};
		else
			s <= sn;
	end

	// link domain, clocked by scl
	always_comb
	begin
		fn = f;
		kn = k;
		kn.sy1 = {s.status[6:4], s.stretch};
		kn.sy2 = k.sy1;
		rdy_l = &k.sy2[3:1];
		byte_l = {f.shift[6:0], sda_i};
		blk_l = !rdy_l && !k.sy2[0] && busy_nack_mode && byte_l != `PCBBH_STATUS_CMD;
		stat_l = 8'h00;
		stat_l[6:4] = k.sy2[3:1];
		// status stays readable while busy so polling works
		rd_l = (k.have_cmd && k.cmd == `PCBBH_STATUS_CMD) ? stat_l : `PCBBH_BUSY_READ_BYTE;
		if (f.state != L_SKIP)
		begin
			if (f.cnt == 4'h8)
			begin
				fn.cnt = 4'h0;
				fn.ack = 1'b0;
				if (f.state == L_RDATA)
				begin
					if (sda_i)
						fn.state = L_SKIP;
					else
						fn.tx = rd_l;
				end
			end
			else
			begin
				fn.shift = byte_l;
				fn.cnt = f.cnt + 4'h1;
				if (f.cnt == 4'h7)
					case (f.state)
						L_ADDR:
							if (byte_l[7:1] != dev_addr)
								fn.state = L_SKIP;
							else if (byte_l[0])
							begin
								fn.ack = 1'b1;
								fn.state = L_RDATA;
								fn.tx = rd_l;
							end
							else
							begin
								fn.ack = 1'b1;
								fn.state = L_CMD;
								kn.have_cmd = 1'b0;
							end
						L_CMD:
						begin
							kn.cmd = byte_l;
							kn.have_cmd = 1'b1;
							kn.idx = 2'h0;
							kn.cmd_tgl = ~k.cmd_tgl;
							fn.ack = cmd_ok(byte_l) && !blk_l;
							fn.state = (cmd_ok(byte_l) && !blk_l) ? L_WDATA : L_SKIP;
						end
						L_WDATA:
							// status is read only; a third data byte is invalid
							if (k.cmd != `PCBBH_STATUS_CMD && k.idx != 2'h2)
							begin
								fn.ack = 1'b1;
								kn.wdata = byte_l;
								kn.wr_hi = k.idx[0];
								kn.idx = k.idx + 2'h1;
								kn.wr_tgl = ~k.wr_tgl;
							end
							else
								fn.state = L_SKIP;
						default: fn.ack = 1'b0;
					endcase
			end
		end
	end

	always_ff @(posedge scl_clk or negedge frm_arst_n)
	begin
		if (!frm_arst_n)
			f <= '{state: L_ADDR, default: '0};
		else
			f <= fn;
	end

	always_ff @(posedge scl_clk or negedge arst_n)
	begin
		if (!arst_n)
			k <= '0;
		else
			k <= kn;
	end

	// sda changes only while scl is low
	always_ff @(negedge scl_clk or negedge frm_arst_n)
	begin
		if (!frm_arst_n)
			sda_drv_ff <= 1'b0;
		else
			sda_drv_ff <= (f.cnt == 4'h8 && f.ack) || (f.state == L_RDATA && f.cnt < 4'h8 && !f.tx[~f.cnt[2:0]]);
	end

	assign scl_o      = 1'b0;
	assign scl_oe_n   = ~s.hold;
	assign sda_o      = 1'b0;
	assign sda_oe_n   = ~sda_drv_ff;
	assign busy_fault = s.fault;
	assign alert_n    = ~s.fault;
	assign exec_valid = s.exec_valid;
	assign exec_cmd   = s.exec_cmd;
	assign exec_data  = s.exec_data;

	a_stretch_gate:
	assert property (@(posedge clock) disable iff (!arst_n)
		!scl_oe_n |-> global_config[`PCBBH_CFG_STRETCH_BIT] && s.fast)
		else $error("scl held low without stretch enabled at fast speed");
	a_calc_flag:
	assert property (@(posedge clock) disable iff (!arst_n)
		wr_evt |=> (!s.status[5])[*2])
		else $error("calc flag not cleared after a write");
	a_busy_exec:
	assert property (@(posedge clock) disable iff (!arst_n)
		s.pstate == P_EXEC |=> !s.status[6] && !s.status[5])
		else $error("busy flag set during execution");
	a_trans_flag:
	assert property (@(posedge clock) disable iff (!arst_n)
		out_transition |=> !s.status[4] && !s.status[6])
		else $error("transition flag set during output transition");
	a_idle_ones:
	assert property (@(posedge clock) disable iff (!arst_n)
		s.pstate == P_IDLE && pick[8] && !s.wdirty && !wr_evt && !out_transition |=> s.status[6:4] == 3'b111)
		else $error("idle device does not report ready");
	a_ready_nofault:
	assert property (@(posedge clock) disable iff (!arst_n)
		cmd_evt && ready && !s.fault |=> !s.fault && !s.hold_req)
		else $error("busy response although ready");
	a_fault_sticky:
	assert property (@(posedge clock) disable iff (!arst_n)
		s.fault && !fault_clear |=> s.fault && !alert_n)
		else $error("busy fault lost without clear");
	a_exec_len:
	assert property (@(posedge clock) disable iff (!arst_n)
		s.pstate == P_FETCH |-> ##EXEC_DLY exec_valid && exec_cmd == $past(s.pcmd, EXEC_DLY))
		else $error("execution length or command wrong");
	a_pend_mark:
	assert property (@(posedge clock) disable iff (!arst_n)
		bus_evt && s.wdirty && !wr_evt |=> s.pend[$past(s.wcmd)])
		else $error("written command not marked for fetch");
	a_unsup_nack:
	assert property (@(posedge scl_clk) disable iff (!frm_arst_n)
		f.state == L_CMD && f.cnt == 4'h7 && !cmd_ok(byte_l) |=> !f.ack && f.state == L_SKIP)
		else $error("unsupported command acknowledged");
	a_busy_nack:
	assert property (@(posedge scl_clk) disable iff (!frm_arst_n)
		f.state == L_CMD && f.cnt == 4'h7 && blk_l |=> !f.ack ##1 !sda_drv_ff)
		else $error("busy command acknowledged in nack mode");
endmodule
`default_nettype wire

// ---- core/pcbbh_regs.svh ----
// command codes, config bit position, reset values and timing counts
`ifndef PCBBH_REGS_SVH
`define PCBBH_REGS_SVH
`define PCBBH_STATUS_CMD      8'hEF
`define PCBBH_STATUS_IDLE     8'h70
`define PCBBH_BUSY_READ_BYTE  8'hFF
`define PCBBH_CFG_STRETCH_BIT 1
`define PCBBH_CLK_KHZ         125000
`define PCBBH_SLOW_SCL_KHZ    100
`define PCBBH_MAX_SCL_KHZ     400
`define PCBBH_SLOW_PERIOD_CYC (`PCBBH_CLK_KHZ / `PCBBH_SLOW_SCL_KHZ)
`define PCBBH_EXEC_CYC_DEF    64
`define PCBBH_CMD_W           8
`define PCBBH_DATA_W          16
`endif

// ---- core/pcbbh_pkg.sv ----
// state types of the command buffer and busy handshake block
package pcbbh_pkg;
	typedef enum logic [2:0] {L_ADDR, L_CMD, L_WDATA, L_RDATA, L_SKIP} pcbbh_lstate_t;
	typedef enum logic [1:0] {P_IDLE, P_FETCH, P_EXEC} pcbbh_pstate_t;
endpackage

// ---- core/pcbbh_mem_if.sv ----
// carrier between the command processor and its write data buffer
`timescale 1ns/1ps
`default_nettype none
interface pcbbh_mem_if #(
	parameter int AW = 8,
	parameter int DW = 16
);
	logic            we;
	logic [DW/8-1:0] wbe;
	logic [AW-1:0]   waddr;
	logic [DW-1:0]   wdata;
	logic [AW-1:0]   raddr;
	logic [DW-1:0]   rdata;
	modport ctl (output we, wbe, waddr, wdata, raddr, input rdata);
	modport mem (input we, wbe, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ---- core/pcbbh_mem.sv ----
// one-entry-per-command write data buffer with registered read
`timescale 1ns/1ps
`default_nettype none
module pcbbh_mem #(
	parameter int AW = 8,
	parameter int DW = 16
)(
	// clock
	input  wire logic clock,
	// buffer access
	pcbbh_mem_if.mem  bus
);
	logic [DW-1:0] ram [2**AW];

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < DW/8; i++)
			if (bus.we && bus.wbe[i])
				ram[bus.waddr][i*8 +: 8] <= bus.wdata[i*8 +: 8];
		bus.rdata <= ram[bus.raddr];
	end
endmodule
`default_nettype wire

// ---- verif/pcbbh_host.sv ----
// pmbus host model bit-banging the open-drain bus
`timescale 1ns/1ps
`default_nettype none
module pcbbh_host #(
	parameter logic [6:0] ADDR = 7'h4F
)(
	// bus wire levels
	input  wire logic scl,
	input  wire logic sda,
	// pull enables, low pulls the wire
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	realtime q_ns;
	int      stuck;
	initial
	begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
		q_ns = 626.25;
		stuck = 0;
	end
	// one scl pulse, waits while the device stretches
	task automatic clk_bit(input logic b, output logic s);
		int n;
		begin
			n = 0;
			sda_oe_n = b;
			#(q_ns);
			scl_oe_n = 1'b1;
			while (scl !== 1'b1 && n < 8000)
			begin
				#8;
				n++;
			end
			if (n == 8000)
				stuck++;
			#(q_ns);
			s = sda;
			#(q_ns);
			scl_oe_n = 1'b0;
			#(q_ns);
		end
	endtask
	task automatic tx_byte(input logic [7:0] d, output logic nak);
		logic s;
		begin
			for (int i = 7; i >= 0; i--)
				clk_bit(d[i], s);
			clk_bit(1'b1, nak);
		end
	endtask
	task automatic start();
		begin
			sda_oe_n = 1'b1;
			#(q_ns);
			scl_oe_n = 1'b1;
			#(q_ns);
			sda_oe_n = 1'b0;
			#(2 * q_ns);
			scl_oe_n = 1'b0;
			#(q_ns);
		end
	endtask
	task automatic stop();
		begin
			sda_oe_n = 1'b0;
			#(q_ns);
			scl_oe_n = 1'b1;
			#(q_ns);
			sda_oe_n = 1'b1;
			#(2 * q_ns);
		end
	endtask
	// a holds the not-ack of each byte
	task automatic write(input logic [7:0] c, input int n, input logic [15:0] w, output logic [3:0] a);
		begin
			a = 4'h0;
			start();
			tx_byte({ADDR, 1'b0}, a[0]);
			tx_byte(c, a[1]);
			if (n > 0)
				tx_byte(w[7:0], a[2]);
			if (n > 1)
				tx_byte(w[15:8], a[3]);
			stop();
		end
	endtask
	task automatic read(input logic [7:0] c, output logic [7:0] d, output logic [3:0] a);
		logic s;
		begin
			a = 4'h0;
			start();
			tx_byte({ADDR, 1'b0}, a[0]);
			tx_byte(c, a[1]);
			start();
			tx_byte({ADDR, 1'b1}, a[2]);
			for (int i = 7; i >= 0; i--)
				clk_bit(1'b1, d[i]);
			clk_bit(1'b1, s);
			stop();
		end
	endtask
	task automatic poll_ready(output logic [7:0] d, output int n);
		logic [3:0] a;
		begin
			n = 0;
			do
			begin
				read(8'hEF, d, a);
				n++;
			end
			while ((d & 8'h70) != 8'h70 && n < 8);
		end
	endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench of command buffering and busy handshake
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clock, arst_n, busy_nack_mode, out_transition, fault_clear;
	logic [7:0]  global_config, exec_cmd;
	logic [15:0] exec_data;
	logic        busy_fault, alert_n, exec_valid, stretched;
	logic        scl_oe_n_dev, sda_oe_n_dev, scl_oe_n_host, sda_oe_n_host;
	logic [23:0] done_q[$];
	int          err_total, check_count;
	wire         scl = scl_oe_n_dev & scl_oe_n_host;
	wire         sda = sda_oe_n_dev & sda_oe_n_host;
	pcbbh_top #(.CMD_SUPPORTED(~(256'h1 << 8'h55)), .EXEC_CYCLES(16)) i_dut (
		.clock(clock), .arst_n(arst_n), .scl_clk(scl), .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n_dev),
		.sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n_dev), .dev_addr(7'h4F), .global_config(global_config),
		.busy_nack_mode(busy_nack_mode), .out_transition(out_transition), .fault_clear(fault_clear),
		.busy_fault(busy_fault), .alert_n(alert_n), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
		.exec_data(exec_data));
	pcbbh_host #(.ADDR(7'h4F)) i_host (.scl(scl), .sda(sda), .scl_oe_n(scl_oe_n_host), .sda_oe_n(sda_oe_n_host));
	always #4 clock = ~clock;
	always @(posedge clock)
		if (exec_valid === 1'b1)
			done_q.push_back({exec_cmd, exec_data});
	always @(negedge scl_oe_n_dev)
		stretched = 1'b1;
	task automatic check(input string w, input logic [23:0] s, input logic [23:0] e);
		begin
			check_count++;
			if (s !== e)
			begin
				err_total++;
				$display("ERROR %s expected %h seen %h", w, e, s);
			end
		end
	endtask
	task automatic complete_run();
		begin
			$display("checks %0d mismatches %0d", check_count, err_total);
			if (err_total == 0 && check_count > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task automatic set_in(input logic ot, input logic nm, input logic [7:0] gc);
		begin
			@(posedge clock);
			out_transition <= ot;
			busy_nack_mode <= nm;
			global_config <= gc;
			stretched = 1'b0;
		end
	endtask
	task automatic wait_exec(input int k);
		for (int i = 0; i < 3000 && done_q.size() < k; i++)
			@(posedge clock);
	endtask
	task automatic clear_fault();
		begin
			@(posedge clock);
			fault_clear <= 1'b1;
			@(posedge clock);
			fault_clear <= 1'b0;
			repeat (2) @(posedge clock);
			check("fault clr", busy_fault, 1'b0);
		end
	endtask
	task automatic t_idle_poll();
		logic [7:0] d;
		int         n;
		begin
			check("oe idle", {scl_oe_n_dev, sda_oe_n_dev, busy_fault, alert_n}, 4'hD);
			i_host.poll_ready(d, n);
			check("status idle", d, 8'h70);
			check("polls", 16'(n), 1);
		end
	endtask
	task automatic t_buffer();
		logic [3:0] a;
		begin
			i_host.write(8'h21, 2, 16'h2000, a);
			check("word nak", a, 4'h0);
			i_host.write(8'h21, 1, 16'h00AB, a);
			check("byte nak", a, 4'h0);
			wait_exec(2);
			check("exec 1", done_q[0], 24'h212000);
			check("exec 2", done_q[1], 24'h2120AB);
			check("no fault", busy_fault, 1'b0);
		end
	endtask
	task automatic t_busy();
		logic [3:0] a;
		logic [7:0] d;
		begin
			set_in(1'b1, 1'b1, 8'h00);
			i_host.read(8'hEF, d, a);
			check("status busy", {a, d}, 12'h020);
			check("ef no fault", busy_fault, 1'b0);
			i_host.write(8'h21, 0, 16'h0000, a);
			check("busy nak", a, 4'h2);
			check("fault set", {busy_fault, alert_n}, 2'h2);
			clear_fault();
			set_in(1'b1, 1'b0, 8'h00);
			i_host.read(8'h30, d, a);
			check("busy ones", {a, d}, 12'h0FF);
			check("fault ones", {busy_fault, alert_n}, 2'h2);
			clear_fault();
		end
	endtask
	task automatic t_stretch();
		logic [3:0] a;
		begin
			set_in(1'b1, 1'b1, 8'h02);
			done_q.delete();
			fork
				i_host.write(8'h21, 1, 16'h0055, a);
				begin
					for (int i = 0; i < 20000 && scl_oe_n_dev !== 1'b0; i++)
						@(posedge clock);
					repeat (100) @(posedge clock);
					out_transition <= 1'b0;
				end
			join
			check("stretched", stretched, 1'b1);
			check("stretch nak", {a, busy_fault}, 5'h00);
			wait_exec(1);
			check("exec 3", done_q[0], 24'h212055);
		end
	endtask
	task automatic t_slow_unsup();
		logic [3:0] a;
		begin
			set_in(1'b1, 1'b1, 8'h02);
			i_host.q_ns = 2525.0;
			i_host.write(8'h21, 0, 16'h0000, a);
			check("slow nak", {a, stretched, busy_fault}, 6'h09);
			clear_fault();
			i_host.q_ns = 626.25;
			set_in(1'b0, 1'b1, 8'h00);
			i_host.write(8'h55, 0, 16'h0000, a);
			check("unsup nak", {a, busy_fault}, 5'h04);
		end
	endtask
	initial
	begin
		clock = 1'b0;
		arst_n = 1'b0;
		busy_nack_mode = 1'b1;
		out_transition = 1'b0;
		fault_clear = 1'b0;
		global_config = 8'h00;
		stretched = 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		repeat (6) @(posedge clock);
		t_idle_poll();
		t_buffer();
		t_busy();
		t_stretch();
		t_slow_unsup();
		check("host wait", 16'(i_host.stuck), 0);
		complete_run();
	end
	initial
	begin
		#1000000;
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
